// [otp_nand_host_cfg.svh]
// Constants for the OTP and internal data move NAND host sequencer
`ifndef OTP_NAND_HOST_CFG_SVH
`define OTP_NAND_HOST_CFG_SVH

// ****************************************
// Clock and pin timing
// ****************************************
`define CLK_NS 4
`define STROBE_LO_NS 12
`define STROBE_HI_NS 10
`define READ_LO_NS 30
`define BUSY_START_NS 100
`define LO_CYC ((`STROBE_LO_NS + `CLK_NS - 1) / `CLK_NS)
`define HI_CYC ((`STROBE_HI_NS + `CLK_NS - 1) / `CLK_NS)
`define RD_LO_CYC ((`READ_LO_NS + `CLK_NS - 1) / `CLK_NS)
`define WB_CYC ((`BUSY_START_NS + `CLK_NS - 1) / `CLK_NS)
`define SYNC_CYC 2

// ****************************************
// Device command bytes
// ****************************************
`define CMD_READ 8'h00
`define CMD_READ_GO 8'h30
`define CMD_MOVE_GO 8'h35
`define CMD_PROG 8'h80
`define CMD_MOVE_PROG 8'h85
`define CMD_PROG_GO 8'h10
`define CMD_FEATURE 8'hef
`define FEAT_OTP 8'h90
`define CMD_STATUS 8'h70
`define CMD_COL_OUT 8'h05
`define CMD_COL_OUT_GO 8'he0
`define CMD_RESET 8'hff

// ****************************************
// OTP area
// ****************************************
`define MODE_NORMAL 8'h00
`define MODE_OTP_OPER 8'h01
`define MODE_OTP_PROT 8'h03
`define OTP_PAGE_FIRST 8'h02
`define OTP_PAGE_LAST 8'h1f
`define OTP_PAGE_BYTES 2112
`define OTP_PART_MAX 8
`define STAT_READY_BIT 5
`define STAT_FAIL_BIT 0

// ****************************************
// Software register map and fields
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_COL 8'h04
`define OFS_ROW 8'h08
`define OFS_LEN 8'h0c
`define OFS_WDATA 8'h10
`define OFS_FPARAM 8'h14
`define OFS_STATUS 8'h18
`define OFS_RDATA 8'h1c
`define ST_BUSY 0
`define ST_READY 1
`define ST_WFULL 2
`define ST_MOVE 3
`define ST_ERR 4
`define ST_PROT 5
`define ST_PROT_PEND 6
`define ST_MODE_LSB 8

`endif

// [otp_nand_host_pkg.sv]
// Types for the OTP and internal data move NAND host sequencer
`default_nettype none
package otp_nand_host_pkg;

	// Orders that software writes into the control register
	typedef enum logic [3:0] {
		OP_FEATURE, OP_READ, OP_READ_MOVE, OP_PROG, OP_PROG_MOVE, OP_RAND_IN,
		OP_CONFIRM, OP_PROTECT, OP_STATUS, OP_RAND_OUT, OP_READ_BYTE, OP_RESET
	} op_t;

	// Kinds of bus step in a command sequence
	typedef enum logic [2:0] {
		K_CMD, K_ADDR, K_WFIX, K_WSTREAM, K_RONE, K_BUSY, K_END
	} kind_t;

	// Pin sequencer states
	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_LO, S_HI, S_WB, S_RB} fsm_t;

	// One step: its kind and the byte it puts on the bus
	typedef struct packed {
		kind_t kind;
		logic [7:0] val;
	} micro_t;

	// Whole state of the host
	typedef struct packed {
		fsm_t st;
		op_t op;
		logic [3:0] idx;
		logic [7:0] cnt;
		logic [12:0] col;
		logic [23:0] row;
		logic [11:0] len;
		logic [11:0] left;
		logic [7:0] fparam;
		logic [7:0] wdata;
		logic wfull;
		logic [7:0] rdata;
		logic [7:0] stat;
		logic [7:0] mode;
		logic prot;
		logic prot_pend;
		logic move_open;
		logic [7:0] last_page;
		logic [3:0] part_cnt;
		logic err;
		logic [31:0] rd_data;
		logic ce_act;
		logic cle;
		logic ale;
		logic we_act;
		logic re_act;
		logic [7:0] io_out;
		logic io_oe;
		logic [1:0] rb_s;
		logic [7:0] io_s1;
		logic [7:0] io_s2;
	} regs_t;

endpackage
`default_nettype wire

// [otp_nand_host.sv]
// Host sequencer for OTP access and internal page move on a NAND device
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "otp_nand_host_cfg.svh"

// How it works
// - Host should verify moved data before program
// - Feature 90h param 01h enters OTP mode
// - OTP pages programmed in ascending order
// - Feature 90h param 03h enters protect mode
// - Param 00h at 90h returns to normal
// - OTP program: 80h, address, data, 10h
// - Status by 70h, bit5 ready, bit0 fail
// - Protect: 80h, four 00h addresses, 00h, 10h
// - OTP read: 00h, five addresses, 30h, busy
module otp_nand_host #(
	parameter int unsigned PAGE_BYTES = `OTP_PAGE_BYTES,
	parameter int unsigned PART_MAX = `OTP_PART_MAX
) (
	input wire logic clk, // Core clock
	input wire logic reset_n, // Asynchronous reset
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	output logic nand_ce_n, // Chip enable
	output logic nand_cle, // Command latch enable
	output logic nand_ale, // Address latch enable
	output logic nand_we_n, // Write strobe to device
	output logic read_strobe_n, // Read strobe to device
	output logic [7:0] io_out, // Data bus out
	output logic io_oe, // Data bus drive enable
	input wire logic [7:0] io_in, // Data bus in
	input wire logic ready_busy_n // Device ready, low while busy
);

	// ****************************************
	// State
	// ****************************************
	otp_nand_host_pkg::regs_t r; // Registered state
	otp_nand_host_pkg::regs_t n; // Next state
	otp_nand_host_pkg::micro_t m; // Current step
	otp_nand_host_pkg::op_t opv; // Order being written
	logic ok; // Order may start
	logic otp; // In OTP operation mode
	logic in_page; // Page lies in the OTP range

	// ****************************************
	// Step table
	// ****************************************
	// Gives the bus step at index i of an order; the address bytes are
	// column low, column high, then the three row bytes.
	function automatic otp_nand_host_pkg::micro_t micro(
		input otp_nand_host_pkg::op_t op,
		input logic [3:0] i,
		input logic [12:0] col,
		input logic [23:0] row,
		input logic [7:0] fp
	);
		otp_nand_host_pkg::micro_t s;
		logic [7:0] ab;
		s.kind = otp_nand_host_pkg::K_END;
		s.val = 8'h00;
		unique case (i)
			4'h1: ab = col[7:0];
			4'h2: ab = {3'h0, col[12:8]};
			4'h3: ab = row[7:0];
			4'h4: ab = row[15:8];
			default: ab = row[23:16];
		endcase
		unique case (op)
			otp_nand_host_pkg::OP_FEATURE: begin
				// Command, feature address, four parameters
				if (i == 4'h0) s = '{otp_nand_host_pkg::K_CMD, `CMD_FEATURE};
				else if (i == 4'h1) s = '{otp_nand_host_pkg::K_ADDR, `FEAT_OTP};
				else if (i == 4'h2) s = '{otp_nand_host_pkg::K_WFIX, fp};
				else if (i <= 4'h5) s = '{otp_nand_host_pkg::K_WFIX, 8'h00};
				else if (i == 4'h6) s.kind = otp_nand_host_pkg::K_BUSY;
			end
			otp_nand_host_pkg::OP_READ, otp_nand_host_pkg::OP_READ_MOVE: begin
				// Plain read and read-for-move differ in the confirm byte
				if (i == 4'h0) s = '{otp_nand_host_pkg::K_CMD, `CMD_READ};
				else if (i <= 4'h5) s = '{otp_nand_host_pkg::K_ADDR, ab};
				else if (i == 4'h6) begin
					s.kind = otp_nand_host_pkg::K_CMD;
					s.val = (op == otp_nand_host_pkg::OP_READ) ? `CMD_READ_GO :
						`CMD_MOVE_GO;
				end else if (i == 4'h7) s.kind = otp_nand_host_pkg::K_BUSY;
			end
			otp_nand_host_pkg::OP_PROG, otp_nand_host_pkg::OP_PROG_MOVE: begin
				// 85h opener keeps the device cache for a move
				if (i == 4'h0) begin
					s.kind = otp_nand_host_pkg::K_CMD;
					s.val = (op == otp_nand_host_pkg::OP_PROG) ? `CMD_PROG :
						`CMD_MOVE_PROG;
				end else if (i <= 4'h5) s = '{otp_nand_host_pkg::K_ADDR, ab};
				else if (i == 4'h6) s.kind = otp_nand_host_pkg::K_WSTREAM;
			end
			otp_nand_host_pkg::OP_RAND_IN: begin
				// New column inside an open program, any number of times
				if (i == 4'h0) s = '{otp_nand_host_pkg::K_CMD, `CMD_MOVE_PROG};
				else if (i <= 4'h2) s = '{otp_nand_host_pkg::K_ADDR, ab};
				else if (i == 4'h3) s.kind = otp_nand_host_pkg::K_WSTREAM;
			end
			otp_nand_host_pkg::OP_CONFIRM: begin
				if (i == 4'h0) s = '{otp_nand_host_pkg::K_CMD, `CMD_PROG_GO};
				else if (i == 4'h1) s.kind = otp_nand_host_pkg::K_BUSY;
			end
			otp_nand_host_pkg::OP_PROTECT: begin
				if (i == 4'h0) s = '{otp_nand_host_pkg::K_CMD, `CMD_PROG};
				else if (i <= 4'h4) s = '{otp_nand_host_pkg::K_ADDR, 8'h00};
				else if (i == 4'h5) s = '{otp_nand_host_pkg::K_WFIX, 8'h00};
				else if (i == 4'h6) s = '{otp_nand_host_pkg::K_CMD, `CMD_PROG_GO};
				else if (i == 4'h7) s.kind = otp_nand_host_pkg::K_BUSY;
			end
			otp_nand_host_pkg::OP_STATUS: begin
				if (i == 4'h0) s = '{otp_nand_host_pkg::K_CMD, `CMD_STATUS};
				else if (i == 4'h1) s.kind = otp_nand_host_pkg::K_RONE;
			end
			otp_nand_host_pkg::OP_RAND_OUT: begin
				if (i == 4'h0) s = '{otp_nand_host_pkg::K_CMD, `CMD_COL_OUT};
				else if (i <= 4'h2) s = '{otp_nand_host_pkg::K_ADDR, ab};
				else if (i == 4'h3) s = '{otp_nand_host_pkg::K_CMD, `CMD_COL_OUT_GO};
			end
			otp_nand_host_pkg::OP_READ_BYTE: begin
				if (i == 4'h0) s.kind = otp_nand_host_pkg::K_RONE;
			end
			otp_nand_host_pkg::OP_RESET: begin
				if (i == 4'h0) s = '{otp_nand_host_pkg::K_CMD, `CMD_RESET};
				else if (i == 4'h1) s.kind = otp_nand_host_pkg::K_BUSY;
			end
			default: s.kind = otp_nand_host_pkg::K_END;
		endcase
		return s;
	endfunction

	// ****************************************
	// Next-state logic
	// ****************************************
	// Synchronisers, register port, order checks and pin sequencer
	always_comb begin
		n = r;
		m = micro(r.op, r.idx, r.col, r.row, r.fparam);
		opv = otp_nand_host_pkg::op_t'(reg_wdata[3:0]);
		otp = (r.mode == `MODE_OTP_OPER);
		in_page = (r.row[7:0] >= `OTP_PAGE_FIRST) && (r.row[7:0] <= `OTP_PAGE_LAST);
		ok = 1'b0;
		// Pins from the device cross in two flops
		n.rb_s = {r.rb_s[0], ready_busy_n};
		n.io_s1 = io_in;
		n.io_s2 = r.io_s1;
		n.rd_data = 32'h0;

		// Pin sequencer
		unique case (r.st)
			otp_nand_host_pkg::S_IDLE: begin
				n.ce_act = 1'b0;
			end
			otp_nand_host_pkg::S_FETCH: begin
				n.cle = 1'b0;
				n.ale = 1'b0;
				unique case (m.kind)
					otp_nand_host_pkg::K_CMD, otp_nand_host_pkg::K_ADDR,
					otp_nand_host_pkg::K_WFIX: begin
						// One write cycle with a fixed byte
						n.cle = (m.kind == otp_nand_host_pkg::K_CMD);
						n.ale = (m.kind == otp_nand_host_pkg::K_ADDR);
						n.io_out = m.val;
						n.io_oe = 1'b1;
						n.we_act = 1'b1;
						n.cnt = 8'(`LO_CYC - 1);
						n.st = otp_nand_host_pkg::S_LO;
					end
					otp_nand_host_pkg::K_WSTREAM: begin
						// Software bytes; waits here while none is held
						if (r.left == 12'h0) begin
							n.idx = r.idx + 4'h1;
						end else if (r.wfull) begin
							n.io_out = r.wdata;
							n.io_oe = 1'b1;
							n.we_act = 1'b1;
							n.wfull = 1'b0;
							n.left = r.left - 12'h1;
							n.cnt = 8'(`LO_CYC - 1);
							n.st = otp_nand_host_pkg::S_LO;
						end
					end
					otp_nand_host_pkg::K_RONE: begin
						// Longer low phase covers access time and sync delay
						n.io_oe = 1'b0;
						n.re_act = 1'b1;
						n.cnt = 8'(`RD_LO_CYC + `SYNC_CYC - 1);
						n.st = otp_nand_host_pkg::S_LO;
					end
					otp_nand_host_pkg::K_BUSY: begin
						n.io_oe = 1'b0;
						n.cnt = 8'(`WB_CYC - 1);
						n.st = otp_nand_host_pkg::S_WB;
					end
					otp_nand_host_pkg::K_END: begin
						n.io_oe = 1'b0;
						n.ce_act = 1'b0;
						n.st = otp_nand_host_pkg::S_IDLE;
						// The parameter just written is the new mode
						if (r.op == otp_nand_host_pkg::OP_FEATURE) n.mode = r.fparam;
						if (r.op == otp_nand_host_pkg::OP_PROTECT) n.prot_pend = 1'b1;
						// Protection counts only after a ready, passing status
						if (r.op == otp_nand_host_pkg::OP_STATUS && r.prot_pend &&
							r.stat[`STAT_READY_BIT]) begin
							n.prot = ~r.stat[`STAT_FAIL_BIT];
							n.prot_pend = 1'b0;
						end
					end
					default: n.st = otp_nand_host_pkg::S_IDLE;
				endcase
			end
			otp_nand_host_pkg::S_LO: begin
				if (r.cnt != 8'h0) begin
					n.cnt = r.cnt - 8'h1;
				end else begin
					n.we_act = 1'b0;
					n.re_act = 1'b0;
					if (r.re_act) begin
						if (r.op == otp_nand_host_pkg::OP_STATUS) n.stat = r.io_s2;
						else n.rdata = r.io_s2;
					end
					n.cnt = 8'(`HI_CYC - 1);
					n.st = otp_nand_host_pkg::S_HI;
				end
			end
			otp_nand_host_pkg::S_HI: begin
				// Data stays on the bus for the hold time
				if (r.cnt != 8'h0) begin
					n.cnt = r.cnt - 8'h1;
				end else begin
					n.st = otp_nand_host_pkg::S_FETCH;
					if (m.kind != otp_nand_host_pkg::K_WSTREAM) n.idx = r.idx + 4'h1;
				end
			end
			otp_nand_host_pkg::S_WB: begin
				// The ready pin is not valid until the busy start time
				if (r.cnt != 8'h0) n.cnt = r.cnt - 8'h1;
				else n.st = otp_nand_host_pkg::S_RB;
			end
			otp_nand_host_pkg::S_RB: begin
				// A refused protected program only yields a short busy
				if (r.rb_s[1]) begin
					n.idx = r.idx + 4'h1;
					n.st = otp_nand_host_pkg::S_FETCH;
				end
			end
		endcase

		// Register reads, answered in the next cycle
		if (reg_rd) begin
			case (reg_addr)
				`OFS_COL: n.rd_data = {19'h0, r.col};
				`OFS_ROW: n.rd_data = {8'h0, r.row};
				`OFS_LEN: n.rd_data = {20'h0, r.len};
				`OFS_FPARAM: n.rd_data = {24'h0, r.fparam};
				`OFS_STATUS: begin
					n.rd_data[`ST_BUSY] = (r.st != otp_nand_host_pkg::S_IDLE);
					n.rd_data[`ST_READY] = r.rb_s[1];
					n.rd_data[`ST_WFULL] = r.wfull;
					n.rd_data[`ST_MOVE] = r.move_open;
					n.rd_data[`ST_ERR] = r.err;
					n.rd_data[`ST_PROT] = r.prot;
					n.rd_data[`ST_PROT_PEND] = r.prot_pend;
					n.rd_data[`ST_MODE_LSB +: 8] = r.mode;
				end
				`OFS_RDATA: n.rd_data = {4'h0, r.part_cnt, r.last_page, r.stat, r.rdata};
				default: n.rd_data = 32'h0;
			endcase
		end

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				`OFS_COL: n.col = reg_wdata[12:0];
				`OFS_ROW: n.row = reg_wdata[23:0];
				`OFS_LEN: n.len = reg_wdata[11:0];
				`OFS_FPARAM: n.fparam = reg_wdata[7:0];
				`OFS_WDATA: begin
					// A byte written over a held one is dropped and flagged; a byte
					// taken by the sequencer in this same cycle frees the holder first
					if (n.wfull) begin
						n.err = 1'b1;
					end else begin
						n.wdata = reg_wdata[7:0];
						n.wfull = 1'b1;
					end
				end
				`OFS_CTRL: begin
					ok = (r.st == otp_nand_host_pkg::S_IDLE) &&
						(reg_wdata[3:0] <= 4'(otp_nand_host_pkg::OP_RESET));
					// Only status, column changes, byte reads, the move program and reset inside a move
					if (r.move_open && !(opv inside {otp_nand_host_pkg::OP_STATUS,
						otp_nand_host_pkg::OP_RAND_OUT, otp_nand_host_pkg::OP_READ_BYTE,
						otp_nand_host_pkg::OP_RAND_IN, otp_nand_host_pkg::OP_PROG_MOVE,
						otp_nand_host_pkg::OP_RESET})) ok = 1'b0;
					if (opv == otp_nand_host_pkg::OP_PROG_MOVE && !r.move_open) ok = 1'b0;
					// OTP reads are allowed whether or not protected
					if (otp && (opv == otp_nand_host_pkg::OP_READ ||
						opv == otp_nand_host_pkg::OP_PROG) && !in_page) ok = 1'b0;
					if (otp && opv == otp_nand_host_pkg::OP_PROG) begin
						if (r.len == 12'h0 || r.len > 12'(PAGE_BYTES)) ok = 1'b0;
						if (r.row[7:0] < r.last_page) ok = 1'b0;
						if (r.row[7:0] == r.last_page &&
							r.part_cnt >= 4'(PART_MAX)) ok = 1'b0;
					end
					if (opv == otp_nand_host_pkg::OP_PROTECT &&
						r.mode != `MODE_OTP_PROT) ok = 1'b0;
					if (ok) begin
						n.op = opv;
						n.idx = 4'h0;
						n.left = r.len;
						n.err = 1'b0;
						n.ce_act = 1'b1;
						n.st = otp_nand_host_pkg::S_FETCH;
						if (opv == otp_nand_host_pkg::OP_READ_MOVE) n.move_open = 1'b1;
						if (opv == otp_nand_host_pkg::OP_PROG_MOVE ||
							opv == otp_nand_host_pkg::OP_RESET) n.move_open = 1'b0;
						// Track page order and partial program count
						if (otp && opv == otp_nand_host_pkg::OP_PROG) begin
							if (r.row[7:0] > r.last_page) begin
								n.last_page = r.row[7:0];
								n.part_cnt = 4'h1;
							end else begin
								n.part_cnt = r.part_cnt + 4'h1;
							end
						end
					end else begin
						n.err = 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// Every strobe is kept active high inside, so reset is all zeros
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata = r.rd_data;
	assign nand_ce_n = ~r.ce_act;
	assign nand_cle = r.cle;
	assign nand_ale = r.ale;
	assign nand_we_n = ~r.we_act;
	assign read_strobe_n = ~r.re_act;
	assign io_out = r.io_out;
	assign io_oe = r.io_oe;

endmodule
`default_nettype wire

// [otp_nand_host_sva.sv]
// Pin timing checker for the OTP NAND host sequencer
`timescale 1ns/1ns
`default_nettype none
module otp_nand_host_chk (
	input wire logic clk, // Clock
	input wire logic reset_n, // Reset
	input wire logic [7:0] reg_addr, // Address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [31:0] reg_rdata, // Read data
	input wire logic nand_ce_n, // Chip enable
	input wire logic nand_cle, // Command latch
	input wire logic nand_ale, // Address latch
	input wire logic nand_we_n, // Device write strobe
	input wire logic read_strobe_n, // Device read strobe
	input wire logic [7:0] io_out, // Bus out
	input wire logic io_oe, // Bus enable
	input wire logic [7:0] io_in, // Bus in
	input wire logic ready_busy_n // Ready pin
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_we_low;
		$fell(nand_we_n) |=> !nand_we_n[*2] ##1 nand_we_n;
	endproperty
	a_we_low: assert property (p_we_low) else $error("write strobe low time");
	property p_we_high;
		$rose(nand_we_n) |=> nand_we_n[*2];
	endproperty
	a_we_high: assert property (p_we_high) else $error("write strobe high time");
	property p_re_low;
		$fell(read_strobe_n) |=> !read_strobe_n[*8] ##1 !read_strobe_n ##1 read_strobe_n;
	endproperty
	a_re_low: assert property (p_re_low) else $error("read strobe low time");
	property p_cle_ctx;
		nand_cle |-> !nand_ale && io_oe;
	endproperty
	a_cle_ctx: assert property (p_cle_ctx) else $error("command cycle context");
	// Latched values must not move while the device may still capture them
	property p_hold;
		!nand_we_n |=> $stable(io_out) && $stable(nand_cle) && $stable(nand_ale);
	endproperty
	a_hold: assert property (p_hold) else $error("bus moved in write cycle");
	property p_read_bus;
		!read_strobe_n |-> !io_oe && nand_we_n && !nand_ce_n;
	endproperty
	a_read_bus: assert property (p_read_bus) else $error("bus driven in read");
	property p_idle;
		nand_ce_n && $past(nand_ce_n) |-> !io_oe && nand_we_n && read_strobe_n;
	endproperty
	a_idle: assert property (p_idle) else $error("activity while deselected");
	property p_first;
		$fell(nand_ce_n) |=> (!nand_we_n && nand_cle) || !read_strobe_n;
	endproperty
	a_first: assert property (p_first) else $error("order start wrong");
	property p_status_go;
		reg_wr && reg_addr == 8'h00 && reg_wdata == 32'h8 && nand_ce_n |-> ##[1:2] !nand_ce_n;
	endproperty
	a_status_go: assert property (p_status_go) else $error("status order not started");
	c_start: cover property ($fell(nand_ce_n));
	c_move_rd: cover property (nand_cle && io_out == 8'h35 && !nand_we_n);
	c_move_pg: cover property (nand_cle && io_out == 8'h85 && !nand_we_n);
	c_read: cover property ($fell(read_strobe_n));
endmodule
bind otp_nand_host otp_nand_host_chk chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.nand_ce_n(nand_ce_n), .nand_cle(nand_cle), .nand_ale(nand_ale), .nand_we_n(nand_we_n),
	.read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
	.ready_busy_n(ready_busy_n));
`default_nettype wire

// [nand_otp_dev_model.sv]
// Behavioural NAND device with OTP area and internal data move
`timescale 1ns/1ns
`default_nettype none
module nand_otp_dev_model #(
	parameter int T_READ = 1000, // array_read_time in ns
	parameter int T_PROG = 2000, // program_busy_time in ns
	parameter int T_SHORT = 200 // protected_program_busy_time in ns
) (
	input wire logic nand_ce_n, // Chip enable
	input wire logic nand_cle, // Command latch
	input wire logic nand_ale, // Address latch
	input wire logic nand_we_n, // Write strobe
	input wire logic read_strobe_n, // Read strobe
	input wire logic [7:0] io_out, // Bus from host
	output logic [7:0] io_in, // Bus to host
	output logic ready_busy_n // Ready pin
);
	// Only four columns per page kept: short transfers only
	logic [7:0] mem [0:31][0:3]; // OTP pages, erased to ones
	logic [7:0] cache [0:3]; // Cache register
	logic [7:0] mode, fa, page, dout; // Mode value persists
	logic [12:0] col; // Column pointer
	logic prot, feat, stat, fail; // Protected, feature entry, status out, fail
	int ac, fpc; // Address and parameter counters
	int part [0:31]; // Partial programs per page
	initial begin
		for (int p = 0; p < 32; p++) begin
			for (int i = 0; i < 4; i++) mem[p][i] = 8'hff;
			part[p] = 0;
		end
		{mode, col, page, prot, feat, stat, fail} = '0;
		ready_busy_n = 1'b1;
	end
	// Released bus shows the inverse, so a late sample cannot pass
	always_comb begin
		dout = stat ? {1'b1, ready_busy_n, ready_busy_n, 4'h0, fail} : cache[col[1:0]];
		io_in = read_strobe_n ? ~dout : dout;
	end
	always @(posedge read_strobe_n) if (nand_ce_n === 1'b0 && !stat) col++;
	task automatic busy(input int t);
		ready_busy_n <= 1'b0;
		ready_busy_n <= #(t) 1'b1;
	endtask
	task automatic prog();
		fail = 1'b0;
		if (mode == 8'h03 && page == 8'h00) begin
			prot = 1'b1;
			busy(T_PROG);
		end else if (mode == 8'h01 && prot) busy(T_SHORT);
		else if (mode == 8'h01) begin
			part[page[4:0]]++;
			fail = page < 8'h02 || page > 8'h1f || part[page[4:0]] > 8;
			if (!fail) for (int i = 0; i < 4; i++) mem[page[4:0]][i] &= cache[i];
			busy(T_PROG);
		end else busy(T_PROG);
	endtask
	// Device latches each cycle on the rising write strobe
	always @(posedge nand_we_n) if (nand_ce_n === 1'b0) begin
		if (nand_cle) begin
			case (io_out)
			8'hef: begin
				feat = 1'b1;
				fpc = 0;
			end
			8'h80: begin
				ac = 0;
				stat = 1'b0;
				for (int i = 0; i < 4; i++) cache[i] = 8'hff;
			end
			8'h00, 8'h85, 8'h05: begin
				ac = 0;
				stat = 1'b0;
			end
			8'h30, 8'h35: begin
				for (int i = 0; i < 4; i++) cache[i] = mode == 8'h01 ? mem[page[4:0]][i] : 8'hc3;
				busy(T_READ);
			end
			8'h10: prog();
			8'h70: stat = 1'b1;
			8'he0: stat = 1'b0;
			8'hff: busy(T_SHORT);
			default: ;
			endcase
		end else if (nand_ale) begin
			if (feat) fa = io_out;
			else if (ac == 0) col = {5'h0, io_out};
			else if (ac == 1) col = {io_out[4:0], col[7:0]};
			else if (ac == 2) page = io_out;
			ac++;
		end else if (feat) begin
			if (fpc == 0 && fa == 8'h90) mode = io_out;
			fpc++;
			if (fpc == 4) begin
				feat = 1'b0;
				busy(T_SHORT);
			end
		end else begin
			cache[col[1:0]] = io_out;
			col++;
		end
	end
endmodule
`default_nettype wire

// [tb_otp_nand_host.sv]
// Self-checking testbench for the OTP NAND host sequencer
`timescale 1ns/1ns
`default_nettype none
`include "otp_nand_host_cfg.svh"
`define CHK(got, exp) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		fails++; \
		$display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end
module tb_otp_nand_host;
	logic clk, reset_n, reg_wr, reg_rd; // Clock, reset, strobes
	logic [7:0] reg_addr; // Register address
	logic [31:0] reg_wdata, q; // Write data, last read
	wire logic [31:0] reg_rdata; // Read data
	wire logic ce_n, cle, ale, we_n, rs_n, oe, rb_n; // Device pins
	wire logic [7:0] io_o, io_i; // Device bus
	int fails, samples_checked, cyc; // Counters
	otp_nand_host uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nand_ce_n(ce_n),
		.nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .read_strobe_n(rs_n), .io_out(io_o),
		.io_oe(oe), .io_in(io_i), .ready_busy_n(rb_n));
	nand_otp_dev_model dev (.nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
		.read_strobe_n(rs_n), .io_out(io_o), .io_in(io_i), .ready_busy_n(rb_n));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// A hang counts as a mismatch
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			test_done();
		end
	end
	task automatic test_done();
		$display("Checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Bus tasks leave one idle cycle so no strobe is set twice in a step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
		@(posedge clk);
	endtask
	task automatic idle();
		do rd(`OFS_STATUS); while (q[`ST_BUSY] !== 1'b0);
	endtask
	task automatic op(input logic [31:0] c);
		wr(`OFS_CTRL, c);
		idle();
	endtask
	// Wait until the held byte is taken, else a second write is dropped
	task automatic feed(input logic [7:0] b);
		do rd(`OFS_STATUS); while (q[`ST_WFULL] !== 1'b0);
		wr(`OFS_WDATA, {24'h0, b});
	endtask
	task automatic cfg(input logic [31:0] c, input logic [31:0] r, input logic [31:0] n);
		wr(`OFS_COL, c);
		wr(`OFS_ROW, r);
		wr(`OFS_LEN, n);
	endtask
	task automatic rbyte();
		op(10);
		rd(`OFS_RDATA);
	endtask
	initial begin
		{reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{fails, samples_checked, cyc} = '0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`OFS_STATUS);
		`CHK(q[15:0], 16'h0002)
		rd(8'h20);
		`CHK(q, 32'h0)
		wr(`OFS_FPARAM, 32'h1);
		op(0);
		rd(`OFS_STATUS);
		`CHK(q[15:8], 8'h01)
		`CHK(dev.mode, 8'h01)
		cfg(0, 2, 2);
		wr(`OFS_CTRL, 3);
		feed(8'haa);
		feed(8'h55);
		idle();
		op(6);
		`CHK(dev.mem[2][1], 8'h55)
		cfg(0, 2, 1);
		wr(`OFS_CTRL, 3);
		feed(8'h0f);
		idle();
		op(6);
		`CHK(dev.mem[2][0], 8'h0a)
		cfg(0, 3, 1);
		wr(`OFS_CTRL, 3);
		feed(8'h11);
		idle();
		cfg(2, 3, 1);
		wr(`OFS_CTRL, 5);
		feed(8'h22);
		idle();
		op(6);
		`CHK({dev.mem[3][0], dev.mem[3][2]}, 16'h1122)
		op(8);
		rd(`OFS_RDATA);
		`CHK(q[15:8] & 8'h21, 8'h20)
		cfg(0, 2, 0);
		op(1);
		rbyte();
		`CHK(q[7:0], 8'h0a)
		rbyte();
		`CHK(q[7:0], 8'h55)
		cfg(1, 2, 0);
		op(9);
		rbyte();
		`CHK(q[7:0], 8'h55)
		cfg(0, 1, 0);
		wr(`OFS_CTRL, 1);
		rd(`OFS_STATUS);
		`CHK(q[`ST_ERR], 1'b1)
		cfg(0, 2, 1);
		wr(`OFS_CTRL, 3);
		rd(`OFS_STATUS);
		`CHK(q[`ST_ERR], 1'b1)
		wr(`OFS_FPARAM, 32'h0);
		op(0);
		rd(`OFS_STATUS);
		`CHK(q[15:8], 8'h00)
		cfg(0, 5, 0);
		op(2);
		op(9);
		rbyte();
		`CHK(q[7:0], 8'hc3)
		wr(`OFS_CTRL, 3);
		rd(`OFS_STATUS);
		`CHK({q[`ST_MOVE], q[`ST_ERR]}, 2'b11)
		op(4);
		`CHK(dev.cache[0], 8'hc3)
		op(6);
		wr(`OFS_FPARAM, 32'h3);
		op(0);
		op(7);
		op(8);
		rd(`OFS_STATUS);
		`CHK(q[`ST_PROT], 1'b1)
		`CHK(dev.prot, 1'b1)
		wr(`OFS_FPARAM, 32'h1);
		op(0);
		cfg(0, 4, 1);
		wr(`OFS_CTRL, 3);
		feed(8'h00);
		idle();
		op(6);
		`CHK(dev.mem[4][0], 8'hff)
		// Seven more partials on the same page reach the limit of eight
		repeat (7) begin
			wr(`OFS_CTRL, 3);
			feed(8'h00);
			idle();
			op(6);
		end
		wr(`OFS_CTRL, 3);
		rd(`OFS_RDATA);
		`CHK(q[27:16], 12'h804)
		rd(`OFS_STATUS);
		`CHK(q[`ST_ERR], 1'b1)
		cfg(0, 2, 0);
		op(1);
		rbyte();
		`CHK(q[7:0], 8'h0a)
		// Reset closes an open move and the order still ends
		op(2);
		op(11);
		rd(`OFS_STATUS);
		`CHK({q[`ST_MOVE], q[`ST_BUSY]}, 2'b00)
		test_done();
	end
endmodule
`default_nettype wire
